// >>> hdl/isr_status_one.sv
// sticky interrupt status register one with read-to-clear and mask gating
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE_01 - each flag latches to one when its condition occurs and holds until the register is read.
// RULE_02 - a read of the status register clears every flag to zero. The code keeps set any flag whose event arrives in the read cycle.
// RULE_03 - in level mode a read leaves set any flag whose source is still active.
// RULE_04 - a flag masked off always reads zero.
// RULE_05 - after reset all flags are zero.
// RULE_06 - with the converter bypassed and the transmitter clock asynchronous, each dropped or repeated sample sets the transmitter slip flag.
// RULE_07 - with block start as an input and the converter unused, each block start pulse sets the transmitter slip flag.
// RULE_08 - bits 7 to 0 are transmitter slip, output slip, rate range, left over, right over, d-to-e, e-to-f, receiver error.
module isr_status_one (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// register access
	input wire logic rd_en,
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data,
	// configuration from companion registers
	input wire logic [7:0] mask,
	input wire logic level_mode,
	// event sources, same clock domain
	input wire isr_pkg::isr_flags_t event_pulse,
	input wire isr_pkg::isr_flags_t source_level,
	input wire isr_pkg::isr_tx_slip_t tx_slip_src
);
	// latched flags before mask gating
	logic [7:0] status;
	logic [7:0] next_status;

	// snapshot handed to the host
	logic [7:0] next_rd_data;

	// set requests of this cycle
	isr_pkg::isr_flags_t set_flags;
	logic [7:0] edge_set;
	logic [7:0] level_set;
	logic [7:0] level_vec;
	logic [7:0] set_vec;
	logic slip_from_sample;
	logic slip_from_block;

	// flags that a read leaves standing
	logic [7:0] keep_vec;
	logic hit;

	// place the named flags at their register positions
	function automatic logic [7:0] flags_to_vec(
		input isr_pkg::isr_flags_t f
	);
		logic [7:0] v;
		v = 8'h00;
		v[isr_pkg::bit_tx_slip] = f.transmitter_slip_flag;
		v[isr_pkg::bit_out_slip] = f.output_port_slip_flag;
		v[isr_pkg::bit_rate_range] = f.rate_range_flag;
		v[isr_pkg::bit_left_ovr] = f.left_overrange_flag;
		v[isr_pkg::bit_right_ovr] = f.right_overrange_flag;
		v[isr_pkg::bit_d_to_e] = f.d_to_e_done_flag;
		v[isr_pkg::bit_e_to_f] = f.e_to_f_done_flag;
		v[isr_pkg::bit_rx_err] = f.receiver_error_flag;
		return v;
	endfunction

	function automatic logic status_hit(
		input logic strobe,
		input logic [6:0] addr
	);
		return strobe && (addr == isr_pkg::status_offset);
	endfunction

	// dropped or repeated sample with the converter bypassed
	function automatic logic sample_slip_cause(
		input isr_pkg::isr_tx_slip_t t
	);
		return t.src_bypassed && t.output_master_clock_async && t.sample_slip;
	endfunction

	// new block start pulse from the pin with the converter unused
	function automatic logic block_slip_cause(
		input isr_pkg::isr_tx_slip_t t
	);
		return t.block_start_is_input && t.src_bypassed && t.block_start_pulse;
	endfunction

	// in level mode a read spares flags whose source still stands
	function automatic logic [7:0] read_keep(
		input logic [7:0] flags,
		input logic level,
		input logic [7:0] active
	);
		logic [7:0] k;
		k = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (level && flags[i] && active[i])
			begin
				k[i] = 1'b1;
			end
		end
		return k;
	endfunction

	// masked flags read as zero but stay latched inside
	function automatic logic [7:0] masked_view(
		input logic [7:0] flags,
		input logic [7:0] enable
	);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			m[i] = flags[i] & enable[i];
		end
		return m;
	endfunction

	// set requests
	always_comb
	begin
		slip_from_sample = sample_slip_cause(tx_slip_src); // RULE_06
		slip_from_block = block_slip_cause(tx_slip_src); // RULE_07
		set_flags = event_pulse;
		set_flags.transmitter_slip_flag = event_pulse.transmitter_slip_flag
			| slip_from_sample
			| slip_from_block;
		edge_set = flags_to_vec(set_flags); // RULE_08
		level_vec = flags_to_vec(source_level);
		level_set = 8'h00;
		if (level_mode)
		begin
			level_set = level_vec;
		end
		set_vec = edge_set | level_set; // RULE_01
	end

	// flag state
	always_comb
	begin
		hit = status_hit(rd_en, rd_addr);
		keep_vec = read_keep(status, level_mode, level_vec); // RULE_03
		next_status = status;
		if (hit)
		begin
			next_status = keep_vec; // RULE_02
		end
		// a new event in the read cycle survives the clear
		next_status = next_status | set_vec; // RULE_01
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			status <= isr_pkg::status_reset; // RULE_05
		end
		else if (clk_en)
		begin
			status <= next_status;
		end
	end

	// read data register, holds the last snapshot until the next hit
	always_comb
	begin
		next_rd_data = rd_data;
		if (hit)
		begin
			next_rd_data = masked_view(status, mask); // RULE_04
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rd_data <= isr_pkg::status_reset; // RULE_05
		end
		else if (clk_en)
		begin
			rd_data <= next_rd_data;
		end
	end
endmodule
`default_nettype wire

// >>> common/isr_pkg.sv
// package for the first interrupt status register block
package isr_pkg;
	localparam logic [6:0] status_offset = 7'h07;
	localparam logic [7:0] status_reset = 8'h00;
	localparam int bit_tx_slip = 7;
	localparam int bit_out_slip = 6;
	localparam int bit_rate_range = 5;
	localparam int bit_left_ovr = 4;
	localparam int bit_right_ovr = 3;
	localparam int bit_d_to_e = 2;
	localparam int bit_e_to_f = 1;
	localparam int bit_rx_err = 0;

	// raw event and level inputs, one bit per flag position
	typedef struct packed {
		logic transmitter_slip_flag;
		logic output_port_slip_flag;
		logic rate_range_flag;
		logic left_overrange_flag;
		logic right_overrange_flag;
		logic d_to_e_done_flag;
		logic e_to_f_done_flag;
		logic receiver_error_flag;
	} isr_flags_t;

	// transmitter slip source qualifiers
	typedef struct packed {
		logic src_bypassed;
		logic output_master_clock_async;
		logic sample_slip;
		logic block_start_is_input;
		logic block_start_pulse;
	} isr_tx_slip_t;
endpackage

// >>> test/isr_checker.sv
// checker for status register one
`timescale 1ns/100ps
`default_nettype none
module isr_checker (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// register access
	input wire logic rd_en,
	input wire logic [6:0] rd_addr,
	input wire logic [7:0] rd_data,
	// configuration
	input wire logic [7:0] mask,
	input wire logic level_mode,
	// event sources
	input wire isr_pkg::isr_flags_t event_pulse,
	input wire isr_pkg::isr_flags_t source_level,
	input wire isr_pkg::isr_tx_slip_t tx_slip_src
);
	logic hit_en;
	logic quiet;
	assign hit_en = clk_en && rd_en && (rd_addr == 7'h07);
	assign quiet = clk_en && !level_mode && (event_pulse == 8'h00) && (tx_slip_src == 5'h00);

	sequence s_clean_read;
		hit_en && quiet;
	endsequence
	sequence s_quiet_gap;
		quiet && !hit_en;
	endsequence
	sequence s_idle_gap;
		clk_en && !hit_en;
	endsequence

chk_reset_zero: assert property (@(posedge clk)
	!nrst |=> rd_data == 8'h00) else $error("read data not zero after reset");
chk_mask_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
	hit_en |=> (rd_data & ~$past(mask)) == 8'h00) else $error("masked bit read");
chk_read_clears: assert property (@(posedge clk) disable iff (!nrst)
	s_clean_read ##1 s_quiet_gap ##1 s_clean_read |=> rd_data == 8'h00)
	else $error("flags not cleared by read");
chk_event_latch: assert property (@(posedge clk) disable iff (!nrst)
	(clk_en && event_pulse.receiver_error_flag) ##1 s_idle_gap ##1 (hit_en && mask[0])
	|=> rd_data[0]) else $error("event flag not latched");
chk_sample_slip: assert property (@(posedge clk) disable iff (!nrst)
	(clk_en && tx_slip_src.src_bypassed && tx_slip_src.output_master_clock_async && tx_slip_src.sample_slip)
	##1 s_idle_gap ##1 (hit_en && mask[7]) |=> rd_data[7]) else $error("sample slip lost");
chk_block_slip: assert property (@(posedge clk) disable iff (!nrst)
	(clk_en && tx_slip_src.block_start_is_input && tx_slip_src.src_bypassed
	&& tx_slip_src.block_start_pulse) ##1 s_idle_gap ##1 (hit_en && mask[7])
	|=> rd_data[7]) else $error("block start slip lost");
chk_level_keeps: assert property (@(posedge clk) disable iff (!nrst)
	(hit_en && level_mode && source_level.left_overrange_flag) ##1 s_idle_gap
	##1 (hit_en && mask[4]) |=> rd_data[4]) else $error("level flag cleared by read");
chk_read_hold: assert property (@(posedge clk) disable iff (!nrst)
	!hit_en |=> $stable(rd_data)) else $error("read data changed without read");
endmodule
bind isr_status_one isr_checker u_chk(.*);
`default_nettype wire

// >>> test/isr_host.sv
// host model reading registers
`timescale 1ns/100ps
`default_nettype none
module isr_host(input wire logic clk,output logic rd_en,output logic [6:0] rd_addr,
	input wire logic [7:0] rd_data);
initial begin rd_en=0;rd_addr=0;end
task rd(logic [6:0] a,output logic [7:0] v);@(posedge clk);#1 rd_en=1;rd_addr=a;
	@(posedge clk);#1 v=rd_data;rd_en=0;endtask
endmodule
`default_nettype wire

// >>> test/isr_status_one_test.sv
// bench for status register one
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin tests_run++;if((a)!==(b)) begin errors++;$display("wrong value %0t %h",$time,a);end end
module isr_status_one_test;
logic clk=0,nrst=0,clk_en=1,level_mode=0,rd_en;logic [6:0] rd_addr;logic [7:0] rd_data,mask=8'hff,d;
isr_pkg::isr_flags_t event_pulse=0,source_level=0;isr_pkg::isr_tx_slip_t tx_slip_src=0;
int errors=0,tests_run=0,n=0;
// rows: tx slip source, event, mask, expected read
logic [31:0] rows[5]='{32'h0080ff80,32'h0001ff01,32'h00ff0f0f,32'h1c00ff80,32'h1300ff80};
isr_status_one u_dut(.*);
isr_host u_host(.*);
initial forever #50 clk=~clk;
always @(posedge clk) if(++n>500) begin errors++;complete_run();end
task complete_run;$display("errors %0d tests %0d",errors,tests_run);
	if(errors==0&&tests_run>0) $display("Test passed");else $display("Test failed");$finish;endtask
task rd(logic [7:0] e);u_host.rd(7'h07,d);`CHK(d,e) endtask
initial
begin
	repeat(5) @(posedge clk);#1 nrst=1;rd(0);
	foreach(rows[i]) begin {tx_slip_src,event_pulse,mask}=rows[i][28:8];#100 {tx_slip_src,event_pulse}=0;
		rd(rows[i][7:0]);rd(0);end
	mask=8'hff;level_mode=1;source_level=8'h10;rd(8'h10);rd(8'h10);source_level=0;rd(8'h10);rd(0);
	level_mode=0;
	event_pulse=8'h02;#100 event_pulse=0;rd(8'h02);
	event_pulse=8'h04;#100 event_pulse=0;
	u_host.rd(7'h06,d);`CHK(d,8'h02)
	rd(8'h04);
	event_pulse=8'h08;clk_en=0;#100 event_pulse=0;clk_en=1;rd(0);
	event_pulse=8'h08;#100 event_pulse=0;clk_en=0;
	u_host.rd(7'h07,d);`CHK(d,8'h00)
	clk_en=1;rd(8'h08);
	fork
		u_host.rd(7'h07,d);
		begin @(posedge clk);#1 event_pulse=8'h20;#100 event_pulse=0;end
	join
	`CHK(d,8'h00)
	rd(8'h20);
	event_pulse=8'h40;#100 event_pulse=0;
	@(posedge clk);#1 nrst=0;@(posedge clk);#1 nrst=1;`CHK(rd_data,8'h00)
	rd(0);
	complete_run();
end
endmodule
`default_nettype wire
